// *** hw/dpt_pkg.sv ***
// What this block does and what its software must do
// (R1) Bits 4 to 2 of count_clock_select choose channel 0's count clock.
// (R2) Bits 7 to 5 of count_clock_select choose channel 1's count clock.
// (R3) Channel 1 clock choice applies only in independent mode; otherwise chained clocking. The reserved mode code also uses the choice.
// (R4) Bits 1 and 0 of count_clock_select are unused; writes ignored.
// (R5) Each channel keeps an 8-bit low reload and an 8-bit high reload.
// (R6) Four separate reload registers: low and high for each channel.
// (R7) Software writes channel 0 reloads before channel 1 in 16-bit mode.
// (R8) Software gives channel 0 equal low and high reloads in 8+8 mode.
// (R9) In independent and 8+8 modes each channel raises its own interrupt.
// (R10) A counter stepping from zero to all-ones underflows and sets its flag.
// (R11) Underflow with interrupt enable set raises that channel's interrupt request.
// (R12) In 16-bit mode the 16-bit wrap sets both underflow flags together.
// (R13) In 16-bit mode either channel's enable lets the underflow request interrupt.
// (R14) Software enables only one channel's interrupt in 16-bit mode.
// (R15) Software clears both flags together in 16-bit mode.
// (R16) An enabled underflow request can start the interrupt-driven transfer service.
// (R17) Software keeps other sharers of the interrupt control quiet for transfers.
// (R18) Writing zero clears a flag, writing one leaves it unchanged.
// (R19) Each phase lasts count clock period times reload value plus one.
// (R20) Low and high reloads load alternately at underflow; the pin toggles then.
// (R21) With run enable clear the counter stops and the pin is held low.
// (R22) Flags and requests reset cleared; a request stands while flag and enable hold.
package dpt_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] DPT_OFF_CCS      = 8'h00;
  localparam logic [7:0] DPT_OFF_CH0_LOW  = 8'h04;
  localparam logic [7:0] DPT_OFF_CH0_HIGH = 8'h08;
  localparam logic [7:0] DPT_OFF_CH1_LOW  = 8'h0C;
  localparam logic [7:0] DPT_OFF_CH1_HIGH = 8'h10;
  localparam logic [7:0] DPT_OFF_CTRL0    = 8'h14;
  localparam logic [7:0] DPT_OFF_CTRL1    = 8'h18;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int DPT_SEL0_LSB   = 2;
  localparam int DPT_SEL1_LSB   = 5;
  localparam int DPT_RUN_BIT    = 7;
  localparam int DPT_PINEN_BIT  = 5;
  localparam int DPT_IRQEN_BIT  = 4;
  localparam int DPT_FLAG_BIT   = 3;
  localparam int DPT_MODE_LSB   = 1;

  // ---------------------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0] DPT_RELOAD_RST = 8'h00;
  localparam logic [2:0] DPT_SEL_RST    = 3'h0;
  localparam int         DPT_PRE_W      = 12;
  localparam logic [DPT_PRE_W-1:0] DPT_PRE_RST = 12'h000;

  // Divide exponents: five machine clock taps, then three timebase taps.
  localparam logic [3:0] DPT_DIV_EXP [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                               4'h4, 4'h9, 4'hB, 4'hC};

  typedef enum logic [1:0] {
    DPT_MODE_INDEP = 2'b00,
    DPT_MODE_8P8   = 2'b01,
    DPT_MODE_RSVD  = 2'b10,
    DPT_MODE_16    = 2'b11
  } dpt_mode_type;

  typedef struct packed {
    logic run;
    logic pinEn;
    logic irqEn;
  } dpt_ctrl_type;

  localparam dpt_ctrl_type DPT_CTRL_RST = '{run: 1'b0, pinEn: 1'b0, irqEn: 1'b0};

endpackage

// *** hw/dpt_tick_select.sv ***
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------------------
// Count clock tap selection
// -----------------------------------------------------------------------------
module dpt_tick_select (
  input  wire logic [11:0] prescale,
  input  wire logic [2:0]  choice,
  output logic             tick
);

  wire logic [12:0] maskWide;
  wire logic [11:0] mask;

  // A tap of divide 2^k fires when the low k prescaler bits are all ones.
  assign maskWide = (13'h0001 << dpt_pkg::DPT_DIV_EXP[choice]) - 13'h0001;
  assign mask     = maskWide[11:0];
  assign tick     = (prescale & mask) == mask;

endmodule

`default_nettype wire

// *** hw/dpt_pulse_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

module dpt_pulse_timer (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             pulsePin0,
  output logic             pulsePin1,
  output logic             underflowIrq0,
  output logic             underflowIrq1
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [11:0]           prescale;
  logic [2:0]            ch0ClockChoice;
  logic [2:0]            ch1ClockChoice;
  logic [7:0]            ch0LowReload;
  logic [7:0]            ch0HighReload;
  logic [7:0]            ch1LowReload;
  logic [7:0]            ch1HighReload;
  dpt_pkg::dpt_ctrl_type ctrl0;
  dpt_pkg::dpt_ctrl_type ctrl1;
  dpt_pkg::dpt_mode_type pairingMode;
  logic                  flag0;
  logic                  flag1;
  logic [7:0]            cnt0;
  logic [7:0]            cnt1;
  logic                  phase0;
  logic                  phase1;
  logic [7:0]            next_cnt0;
  logic [7:0]            next_cnt1;
  logic                  next_phase0;
  logic                  next_phase1;
  logic                  wrPend;
  logic [7:0]            wrAddr;
  logic                  rdLoad;
  logic [7:0]            rdAddr;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire logic        addrValid;
  wire logic        readStart;
  wire logic        wrCcs;
  wire logic        wrCh0Low;
  wire logic        wrCh0High;
  wire logic        wrCh1Low;
  wire logic        wrCh1High;
  wire logic        wrCtrl0;
  wire logic        wrCtrl1;
  wire logic [7:0]  wByte;
  wire logic [7:0]  ccsRead;
  wire logic [7:0]  ctrl0Read;
  wire logic [7:0]  ctrl1Read;
  wire logic [7:0]  readByte;

  // Only the low byte of a word carries data; hsize is accepted as a word.
  assign addrValid = hsel & hready & htrans[1];
  assign readStart = addrValid & ~hwrite;
  assign wByte     = hwdata[7:0];
  assign wrCcs     = wrPend & (wrAddr == dpt_pkg::DPT_OFF_CCS);
  assign wrCh0Low  = wrPend & (wrAddr == dpt_pkg::DPT_OFF_CH0_LOW);
  assign wrCh0High = wrPend & (wrAddr == dpt_pkg::DPT_OFF_CH0_HIGH);
  assign wrCh1Low  = wrPend & (wrAddr == dpt_pkg::DPT_OFF_CH1_LOW);
  assign wrCh1High = wrPend & (wrAddr == dpt_pkg::DPT_OFF_CH1_HIGH);
  assign wrCtrl0   = wrPend & (wrAddr == dpt_pkg::DPT_OFF_CTRL0);
  assign wrCtrl1   = wrPend & (wrAddr == dpt_pkg::DPT_OFF_CTRL1);

  // Unused bits read as zero rather than undefined, which is safe for software.
  assign ccsRead   = {ch1ClockChoice, ch0ClockChoice, 2'b00};  // [R4]
  assign ctrl0Read = {ctrl0.run, 1'b0, ctrl0.pinEn, ctrl0.irqEn, flag0, 3'b000};
  assign ctrl1Read = {ctrl1.run, 1'b0, ctrl1.pinEn, ctrl1.irqEn, flag1,
                      pairingMode, 1'b0};
  assign readByte  = (rdAddr == dpt_pkg::DPT_OFF_CCS)      ? ccsRead :
                     (rdAddr == dpt_pkg::DPT_OFF_CH0_LOW)  ? ch0LowReload :
                     (rdAddr == dpt_pkg::DPT_OFF_CH0_HIGH) ? ch0HighReload :
                     (rdAddr == dpt_pkg::DPT_OFF_CH1_LOW)  ? ch1LowReload :
                     (rdAddr == dpt_pkg::DPT_OFF_CH1_HIGH) ? ch1HighReload :
                     (rdAddr == dpt_pkg::DPT_OFF_CTRL0)    ? ctrl0Read :
                     (rdAddr == dpt_pkg::DPT_OFF_CTRL1)    ? ctrl1Read : 8'h00;

  // Bus phase tracking. Reads take one wait state so hrdata is a flop that
  // already reflects a write completed in the preceding data phase.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
      rdLoad    <= 1'b0;
      rdAddr    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wrPend    <= addrValid & hwrite;
      wrAddr    <= addrValid ? haddr[7:0] : wrAddr;
      rdLoad    <= readStart;
      rdAddr    <= readStart ? haddr[7:0] : rdAddr;
      hreadyout <= ~readStart;
      hresp     <= 1'b0;
      hrdata    <= rdLoad ? {24'h00_0000, readByte} : hrdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ch0ClockChoice <= dpt_pkg::DPT_SEL_RST;
      ch1ClockChoice <= dpt_pkg::DPT_SEL_RST;
      ch0LowReload   <= dpt_pkg::DPT_RELOAD_RST;
      ch0HighReload  <= dpt_pkg::DPT_RELOAD_RST;
      ch1LowReload   <= dpt_pkg::DPT_RELOAD_RST;
      ch1HighReload  <= dpt_pkg::DPT_RELOAD_RST;
      ctrl0          <= dpt_pkg::DPT_CTRL_RST;
      ctrl1          <= dpt_pkg::DPT_CTRL_RST;
      pairingMode    <= dpt_pkg::DPT_MODE_INDEP;
    end else begin
      if (wrCcs) begin
        ch0ClockChoice <= wByte[dpt_pkg::DPT_SEL0_LSB +: 3];  // [R1]
        ch1ClockChoice <= wByte[dpt_pkg::DPT_SEL1_LSB +: 3];  // [R2]
      end
      if (wrCh0Low)  ch0LowReload  <= wByte;  // [R5] [R6]
      if (wrCh0High) ch0HighReload <= wByte;
      if (wrCh1Low)  ch1LowReload  <= wByte;
      if (wrCh1High) ch1HighReload <= wByte;
      if (wrCtrl0) begin
        ctrl0 <= '{run: wByte[dpt_pkg::DPT_RUN_BIT], pinEn: wByte[dpt_pkg::DPT_PINEN_BIT],
                   irqEn: wByte[dpt_pkg::DPT_IRQEN_BIT]};
      end
      if (wrCtrl1) begin
        ctrl1 <= '{run: wByte[dpt_pkg::DPT_RUN_BIT], pinEn: wByte[dpt_pkg::DPT_PINEN_BIT],
                   irqEn: wByte[dpt_pkg::DPT_IRQEN_BIT]};
        pairingMode <= dpt_pkg::dpt_mode_type'(wByte[dpt_pkg::DPT_MODE_LSB +: 2]);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Count clocks
  // ---------------------------------------------------------------------------
  wire logic is16;
  wire logic is8p8;
  wire logic runBoth;
  wire logic runEff0;
  wire logic runEff1;
  wire logic tick0;
  wire logic tick1Sel;
  wire logic tick1;
  wire logic [15:0] wideCnt;
  wire logic uf0Evt;
  wire logic uf1Evt;

  // The free prescaler feeds both tap selectors from one shared count.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prescale <= dpt_pkg::DPT_PRE_RST;
    end else begin
      prescale <= prescale + 12'h001;
    end
  end

  dpt_tick_select u_tick0 (
    .prescale (prescale),
    .choice   (ch0ClockChoice),
    .tick     (tick0)
  );

  dpt_tick_select u_tick1 (
    .prescale (prescale),
    .choice   (ch1ClockChoice),
    .tick     (tick1Sel)
  );

  // The reserved mode code behaves as independent operation.
  assign is16    = pairingMode == dpt_pkg::DPT_MODE_16;
  assign is8p8   = pairingMode == dpt_pkg::DPT_MODE_8P8;
  assign runBoth = ctrl0.run & ctrl1.run;
  assign runEff0 = is16 ? runBoth : ctrl0.run;
  assign runEff1 = is16 ? runBoth : ctrl1.run;
  assign tick1   = is16 ? tick0 : (is8p8 ? uf0Evt : tick1Sel);  // [R3]
  assign wideCnt = {cnt1, cnt0};
  assign uf0Evt  = is16 ? (runBoth & tick0 & (wideCnt == 16'h0000))
                        : (ctrl0.run & tick0 & (cnt0 == 8'h00));  // [R10] [R12]
  assign uf1Evt  = is16 ? uf0Evt : (ctrl1.run & tick1 & (cnt1 == 8'h00));  // [R9] [R12]

  // ---------------------------------------------------------------------------
  // Down counters
  // ---------------------------------------------------------------------------
  // Phase low counts the low reload; each underflow loads the other reload,
  // so a phase lasts reload plus one count clocks.
  always_comb begin
    next_cnt0   = cnt0;
    next_cnt1   = cnt1;
    next_phase0 = phase0;
    next_phase1 = phase1;
    if (is16) begin
      if (!runBoth) begin
        next_cnt0   = ch0LowReload;  // [R21]
        next_cnt1   = ch1LowReload;
        next_phase0 = 1'b0;
        next_phase1 = 1'b0;
      end else if (uf0Evt) begin
        {next_cnt1, next_cnt0} = phase0 ? {ch1LowReload, ch0LowReload}
                                        : {ch1HighReload, ch0HighReload};  // [R20]
        next_phase0 = ~phase0;
        next_phase1 = ~phase0;
      end else if (tick0) begin
        {next_cnt1, next_cnt0} = wideCnt - 16'h0001;  // [R19]
      end
    end else begin
      if (!ctrl0.run) begin
        next_cnt0   = ch0LowReload;  // [R21]
        next_phase0 = 1'b0;
      end else if (uf0Evt) begin
        next_cnt0   = phase0 ? ch0LowReload : ch0HighReload;  // [R20]
        next_phase0 = ~phase0;
      end else if (tick0) begin
        next_cnt0 = cnt0 - 8'h01;  // [R19]
      end
      if (!ctrl1.run) begin
        next_cnt1   = ch1LowReload;
        next_phase1 = 1'b0;
      end else if (uf1Evt) begin
        next_cnt1   = phase1 ? ch1LowReload : ch1HighReload;
        next_phase1 = ~phase1;
      end else if (tick1) begin
        next_cnt1 = cnt1 - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt0   <= dpt_pkg::DPT_RELOAD_RST;
      cnt1   <= dpt_pkg::DPT_RELOAD_RST;
      phase0 <= 1'b0;
      phase1 <= 1'b0;
    end else begin
      cnt0   <= next_cnt0;
      cnt1   <= next_cnt1;
      phase0 <= next_phase0;
      phase1 <= next_phase1;
    end
  end

  // ---------------------------------------------------------------------------
  // Flags, requests and pins
  // ---------------------------------------------------------------------------
  // An underflow in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag0         <= 1'b0;  // [R22]
      flag1         <= 1'b0;
      underflowIrq0 <= 1'b0;
      underflowIrq1 <= 1'b0;
      pulsePin0     <= 1'b0;
      pulsePin1     <= 1'b0;
    end else begin
      flag0 <= uf0Evt | (flag0 & ~(wrCtrl0 & ~wByte[dpt_pkg::DPT_FLAG_BIT]));  // [R18]
      flag1 <= uf1Evt | (flag1 & ~(wrCtrl1 & ~wByte[dpt_pkg::DPT_FLAG_BIT]));
      // Each request line may also start the transfer service downstream.
      underflowIrq0 <= flag0 & ctrl0.irqEn;  // [R11] [R13] [R16] [R22]
      underflowIrq1 <= flag1 & ctrl1.irqEn;
      pulsePin0     <= runEff0 & ctrl0.pinEn & phase0;  // [R20] [R21]
      pulsePin1     <= runEff1 & ctrl1.pinEn & phase1;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence seqLowUnderflow0;
    !is16 && uf0Evt && !phase0;
  endsequence

  sequence seqHighPhaseLoaded0;
    phase0 && (cnt0 == $past(ch0HighReload));
  endsequence

  AST_SEL0_FIELD: assert property (wrCcs |=> ch0ClockChoice == $past(wByte[4:2]))  // [R1]
    else $error("Channel 0 clock choice not taken from bits 4 to 2.");
  AST_SEL1_FIELD: assert property (wrCcs |=> ch1ClockChoice == $past(wByte[7:5]))  // [R2]
    else $error("Channel 1 clock choice not taken from bits 7 to 5.");
  AST_CH1_CLOCK: assert property (is8p8 && ctrl1.run && !uf0Evt |=> $stable(cnt1))  // [R3]
    else $error("Channel 1 not clocked by channel 0 underflow in 8+8 mode.");
  AST_UNUSED_BITS: assert property (rdLoad |=> hrdata[1:0] == 2'b00 || $past(rdAddr) != 8'h00)  // [R4]
    else $error("Unused clock select bits did not read as zero.");
  AST_RELOAD_HIGH: assert property (seqLowUnderflow0 |=> seqHighPhaseLoaded0)  // [R20]
    else $error("High reload not loaded after a low phase underflow.");
  AST_FLAG_SET: assert property (uf0Evt |=> flag0 ##1 (flag0 || $past(wrCtrl0)))  // [R10]
    else $error("Underflow did not set channel 0 flag.");
  AST_WIDE_BOTH: assert property (is16 && uf0Evt |-> uf1Evt ##1 (flag0 && flag1))  // [R12]
    else $error("16-bit underflow did not set both flags together.");
  AST_IRQ_FOLLOW: assert property (flag1 && ctrl1.irqEn |=> underflowIrq1)  // [R11]
    else $error("Channel 1 request missing with flag and enable set.");
  AST_FLAG_KEEP: assert property (flag0 && wrCtrl0 && wByte[3] |=> flag0)  // [R18]
    else $error("Writing one changed channel 0 flag.");
  AST_STOP_LOW: assert property (!runEff0 [*2] |-> !pulsePin0 && cnt0 == $past(ch0LowReload))  // [R21]
    else $error("Stopped channel 0 did not hold its pin low.");

endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_top;

  // ---------------------------------------------------------------------------
  // Signals and constants
  // ---------------------------------------------------------------------------
  logic        core_clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pulsePin0;
  logic        pulsePin1;
  logic        underflowIrq0;
  logic        underflowIrq1;
  int          n_errors;
  int          n_compared;

  // Mode control bits; a flag bit written as one leaves the flag alone.
  localparam logic [7:0] C_RUN = 8'h80;
  localparam logic [7:0] C_PIN = 8'h20;
  localparam logic [7:0] C_IEN = 8'h10;
  localparam logic [7:0] C_FLG = 8'h08;
  localparam logic [7:0] C_M88 = 8'h02;
  localparam logic [7:0] C_M16 = 8'h06;

  // The only slave's ready is the bus ready; every transfer is one word.
  dpt_pulse_timer i_dut (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (3'h2),
    .hwdata        (hwdata),
    .hready        (hreadyout),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .hrdata        (hrdata),
    .pulsePin0     (pulsePin0),
    .pulsePin1     (pulsePin1),
    .underflowIrq0 (underflowIrq0),
    .underflowIrq1 (underflowIrq1)
  );

  // Free-running 20 MHz clock.
  always #25 core_clk = ~core_clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    n_errors++;
    $display("BAD %s expected event seen timeout", what);
    finish_test();
  endtask

  // Ready is a registered output, so the value at the falling edge is what the next rise samples.
  task automatic wait_ready();
    int k;
    k = 0;
    @(negedge core_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) give_up("hreadyout");
      @(negedge core_clk);
    end
  endtask

  // One single transfer; entered just after a rising edge and left on one.
  task automatic xfer(input logic wrt, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wrt;
    wait_ready();
    @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rdat = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, a, wd, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
    xfer(1'b0, a, 32'h0, rdat);
  endtask

  function automatic logic pin(input int ch);
    return (ch == 1) ? pulsePin1 : pulsePin0;
  endfunction

  // Counts falling edges until the pin shows the level; the first one seen counts as one.
  task automatic wait_pin(input int ch, input logic lvl, output int n);
    n = 1;
    @(negedge core_clk);
    while (pin(ch) !== lvl) begin
      n++;
      if (n > 20000) give_up("pulse pin");
      @(negedge core_clk);
    end
  endtask

  // Skips any partial phase, then measures one full high and one full low phase.
  task automatic measure(input int ch, output int hi, output int lo);
    int x;
    wait_pin(ch, 1'b0, x);
    wait_pin(ch, 1'b1, x);
    wait_pin(ch, 1'b0, hi);
    wait_pin(ch, 1'b1, lo);
    @(posedge core_clk);
  endtask

  // Returns at a falling edge where either request line is high.
  task automatic wait_irq();
    int n;
    n = 0;
    @(negedge core_clk);
    while (underflowIrq0 !== 1'b1 && underflowIrq1 !== 1'b1) begin
      n++;
      if (n > 20000) give_up("underflow request");
      @(negedge core_clk);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_regs();
    logic [7:0]  offs [0:3];
    logic [31:0] d;
    offs = '{dpt_pkg::DPT_OFF_CH0_LOW, dpt_pkg::DPT_OFF_CH0_HIGH,
             dpt_pkg::DPT_OFF_CH1_LOW, dpt_pkg::DPT_OFF_CH1_HIGH};
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], d);
      check("reload reset", 32'h0, d);
      wr(offs[i], 32'hFFFFFF00 | (32'h5A + 32'(i) * 32'h11));
    end
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], d);
      check("reload value", 32'h5A + 32'(i) * 32'h11, d);
    end
    wr(dpt_pkg::DPT_OFF_CCS, 32'hFF);
    rd(dpt_pkg::DPT_OFF_CCS, d);
    check("clock select", 32'hFC, d);
    wr(8'h40, 32'hFF);
    rd(8'h40, d);
    check("unmapped read", 32'h0, d);
    $display("test regs done");
  endtask

  task automatic test_ch0();
    int          hi;
    int          lo;
    logic [31:0] d;
    wr(dpt_pkg::DPT_OFF_CCS, 32'h0);
    wr(dpt_pkg::DPT_OFF_CH0_LOW, 32'h2);
    wr(dpt_pkg::DPT_OFF_CH0_HIGH, 32'h1);
    wr(dpt_pkg::DPT_OFF_CTRL0, C_RUN | C_PIN | C_IEN | C_FLG);
    measure(0, hi, lo);
    check("ch0 high width", 32'd2, hi);
    check("ch0 low width", 32'd3, lo);
    check("irq0 raised", 32'h1, underflowIrq0);
    check("irq1 quiet", 32'h0, underflowIrq1);
    // Stopping keeps the flag because its bit is written as one.
    wr(dpt_pkg::DPT_OFF_CTRL0, C_IEN | C_FLG);
    repeat (2) @(posedge core_clk);
    check("pin0 stopped", 32'h0, pulsePin0);
    check("irq0 stands", 32'h1, underflowIrq0);
    rd(dpt_pkg::DPT_OFF_CTRL0, d);
    check("flag0 set", 32'h1, d[3]);
    wr(dpt_pkg::DPT_OFF_CTRL0, C_IEN);
    rd(dpt_pkg::DPT_OFF_CTRL0, d);
    check("flag0 cleared", 32'h0, d[3]);
    repeat (2) @(posedge core_clk);
    check("irq0 dropped", 32'h0, underflowIrq0);
    $display("test ch0 done");
  endtask

  task automatic test_choice();
    int hi;
    int lo;
    wr(dpt_pkg::DPT_OFF_CH0_LOW, 32'h0);
    wr(dpt_pkg::DPT_OFF_CH0_HIGH, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wr(dpt_pkg::DPT_OFF_CTRL0, 32'h0);
      wr(dpt_pkg::DPT_OFF_CCS, 32'(k) << 2);
      wr(dpt_pkg::DPT_OFF_CTRL0, C_RUN | C_PIN);
      measure(0, hi, lo);
      check("ch0 tap high", 32'd1 << dpt_pkg::DPT_DIV_EXP[k], hi);
      check("ch0 tap low", 32'd1 << dpt_pkg::DPT_DIV_EXP[k], lo);
    end
    wr(dpt_pkg::DPT_OFF_CTRL0, 32'h0);
    $display("test choice done");
  endtask

  task automatic test_ch1();
    int hi;
    int lo;
    wr(dpt_pkg::DPT_OFF_CCS, 32'h40);
    wr(dpt_pkg::DPT_OFF_CH1_LOW, 32'h0);
    wr(dpt_pkg::DPT_OFF_CH1_HIGH, 32'h0);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_RUN | C_PIN | C_IEN | C_FLG);
    measure(1, hi, lo);
    check("ch1 tap high", 32'd4, hi);
    check("ch1 tap low", 32'd4, lo);
    check("irq1 own", 32'h1, underflowIrq1);
    check("irq0 apart", 32'h0, underflowIrq0);
    // In 8+8 channel 1 steps on channel 0 underflows, not on its own tap.
    wr(dpt_pkg::DPT_OFF_CTRL1, 32'h0);
    wr(dpt_pkg::DPT_OFF_CH0_LOW, 32'h1);
    wr(dpt_pkg::DPT_OFF_CH0_HIGH, 32'h1);
    wr(dpt_pkg::DPT_OFF_CTRL0, C_RUN | C_IEN);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_RUN | C_PIN | C_M88);
    measure(1, hi, lo);
    check("chained high", 32'd2, hi);
    check("chained low", 32'd2, lo);
    check("irq0 in 8+8", 32'h1, underflowIrq0);
    check("irq1 in 8+8", 32'h0, underflowIrq1);
    wr(dpt_pkg::DPT_OFF_CTRL1, 32'h0);
    wr(dpt_pkg::DPT_OFF_CTRL0, 32'h0);
    $display("test ch1 done");
  endtask

  task automatic test_16();
    int          hi;
    int          lo;
    logic [31:0] d;
    wr(dpt_pkg::DPT_OFF_CCS, 32'hE0);
    wr(dpt_pkg::DPT_OFF_CH0_LOW, 32'h1);
    wr(dpt_pkg::DPT_OFF_CH0_HIGH, 32'h2);
    wr(dpt_pkg::DPT_OFF_CH1_LOW, 32'h0);
    wr(dpt_pkg::DPT_OFF_CH1_HIGH, 32'h0);
    wr(dpt_pkg::DPT_OFF_CTRL0, C_RUN | C_PIN);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_RUN | C_PIN | C_M16);
    measure(0, hi, lo);
    check("wide high", 32'd3, hi);
    check("wide low", 32'd2, lo);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_FLG | C_M16);
    wr(dpt_pkg::DPT_OFF_CTRL0, C_FLG);
    rd(dpt_pkg::DPT_OFF_CTRL0, d);
    check("wide flag0", 32'h1, d[3]);
    rd(dpt_pkg::DPT_OFF_CTRL1, d);
    check("wide flag1", 32'h1, d[3]);
    wr(dpt_pkg::DPT_OFF_CTRL0, 32'h0);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_M16);
    wr(dpt_pkg::DPT_OFF_CTRL0, C_RUN | C_IEN);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_RUN | C_IEN | C_M16);
    wait_irq();
    check("both requests together", 32'h3, {30'h0, underflowIrq1, underflowIrq0});
    @(posedge core_clk);
    wr(dpt_pkg::DPT_OFF_CTRL0, 32'h0);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_M16);
    wr(dpt_pkg::DPT_OFF_CTRL0, C_RUN);
    wr(dpt_pkg::DPT_OFF_CTRL1, C_RUN | C_IEN | C_M16);
    wait_irq();
    check("wide request on ch1", 32'h1, underflowIrq1);
    check("no request on ch0", 32'h0, underflowIrq0);
    @(posedge core_clk);
    wr(dpt_pkg::DPT_OFF_CTRL0, 32'h0);
    wr(dpt_pkg::DPT_OFF_CTRL1, 32'h0);
    $display("test 16 done");
  endtask

  // Reset for two cycles, then the scenarios in turn.
  initial begin
    n_errors = 0;
    n_compared = 0;
    core_clk = 1'b0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    check("irq in reset", 32'h0, {underflowIrq1, underflowIrq0});
    check("pins in reset", 32'h0, {pulsePin1, pulsePin0});
    resetn <= 1'b1;
    @(posedge core_clk);
    test_regs();
    test_ch0();
    test_choice();
    test_ch1();
    test_16();
    finish_test();
  end

endmodule

`default_nettype wire
